// ==== design/rdr_consts.vh ====
// constants for the receive data-recovery configuration block
`ifndef RDR_CONSTS_VH
`define RDR_CONSTS_VH
// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define RDR_IDX_RX_CONFIG       8'h0E
`define RDR_IDX_ENERGY_LEVEL    8'h15
`define RDR_IDX_SLICE_LEVEL     8'h1D
`define RDR_IDX_FILTER_SLICE    8'h1E
`define RDR_IDX_CDR_OPTIONS     8'h1F
`define RDR_IDX_DATA_FORMAT     8'h0B
`define RDR_IDX_LOOP_COEF       8'h2B
`define RDR_IDX_STATUS          8'h30
`define RDR_IDX_RATE_SELECT     8'h31
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RDR_RXC_WAKE_BIT        0
`define RDR_RXC_GATE_BIT        1
`define RDR_RXC_MOD_BIT         2
`define RDR_CDRO_FMMODE_BIT     0
`define RDR_FMT_MAN_BIT         3
`define RDR_FS_BW_HI            7
`define RDR_FS_BW_LO            5
`define RDR_FS_UNUSED_MASK      8'hEF
`define RDR_FS_REF_HI           3
`define RDR_FS_REF_LO           2
`define RDR_FS_HYST_HI          1
`define RDR_FS_HYST_LO          0
// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define RDR_REF_FIXED_A         2'h0
`define RDR_REF_AVERAGE         2'h1
`define RDR_REF_PEAK            2'h2
`define RDR_REF_FIXED_B         2'h3
`define RDR_RST_ENERGY          8'h00
`define RDR_RST_SLICE           8'h00
`define RDR_RST_FILTER          8'h00
`define RDR_RST_RXC             8'h00
`define RDR_RST_CDRO            8'h00
`define RDR_RST_FMT             8'h00
`define RDR_RST_COEF            8'h00
`define RDR_RST_RATE            8'h00
`define RDR_SOF_MAN             8'h66
`define RDR_DEMOD_FFT           2'h1
`define RDR_DEMOD_PLL           2'h2
`define RDR_DEMOD_AM            2'h0
`define RDR_HYST_MV_0           8'h00
`define RDR_HYST_MV_1           8'h19
`define RDR_HYST_MV_2           8'h32
`define RDR_HYST_MV_3           8'h64
`endif

// ==== design/rdr_config.v ====
// register bank and routing for receive data-recovery configuration
`timescale 1ns/100ps
`include "rdr_consts.vh"
module rdr_config #(
  parameter [8*8-1:0] RATE_COEF_TABLE = 64'h8070605040302010
) (
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        noise_floor_valid_i,
  input  wire [7:0]  noise_floor_level_i,
  input  wire [7:0]  energy_level_i,
  input  wire [7:0]  peak_level_i,
  input  wire [7:0]  average_level_i,
  output reg  [7:0]  energy_threshold_o,
  output reg  [7:0]  slice_threshold_o,
  output reg  [2:0]  signal_strength_level_filter_bw_select_o,
  output reg  [7:0]  slice_hysteresis_mv_o,
  output reg  [7:0]  fsk_loop_filter_coef_o,
  output reg         rx_modulation_select_o,
  output reg  [1:0]  demod_select_o,
  output reg         clock_data_recovery_en_o,
  output reg         clock_data_recovery_rst_o,
  output reg  [7:0]  sof_pattern_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [7:0] energy_q;
  reg  [7:0] slice_q;
  reg  [7:0] filter_q;
  reg  [7:0] rxc_q;
  reg  [7:0] cdro_q;
  reg  [7:0] fmt_q;
  reg  [7:0] coef_q;
  reg  [7:0] rate_q;
  reg        energy_met_q;
  reg  [7:0] rdata_d;
  reg        addr_ok_d;
  wire [9:0] idx;
  wire       acc;
  wire       wr;
  wire       manch;
  wire [1:0] ref_sel;
  wire       wr_en;
  wire       wr_rxc;
  wire       wr_energy;
  wire       wr_slice;
  wire       wr_filter;
  wire       wr_cdro;
  wire       wr_fmt;
  wire       wr_coef;
  wire       wr_rate;
  wire       rate_discrete;
  wire [7:0] wdata;
  // one decode shared by every write strobe
  function reg_hit;
    input [9:0] a;
    input [7:0] index;
    begin
      reg_hit = (a == {2'b00, index});
    end
  endfunction
  function [7:0] hyst_mv;
    input [1:0] code;
    begin
      case (code)
        2'h0:    hyst_mv = `RDR_HYST_MV_0;
        2'h1:    hyst_mv = `RDR_HYST_MV_1;
        2'h2:    hyst_mv = `RDR_HYST_MV_2;
        default: hyst_mv = `RDR_HYST_MV_3;
      endcase
    end
  endfunction
  function [7:0] half_level;
    input [7:0] lvl;
    begin
      half_level = {1'b0, lvl[7:1]};
    end
  endfunction
  assign idx     = paddr_i[11:2];
  assign acc     = psel_i & penable_i;
  assign wr      = acc & pwrite_i & addr_ok_d;
  assign manch   = fmt_q[`RDR_FMT_MAN_BIT];
  assign ref_sel = filter_q[`RDR_FS_REF_HI:`RDR_FS_REF_LO];
  assign wdata         = pwdata_i[7:0];
  assign wr_en         = wr & pready_o;
  assign wr_rxc        = wr_en & reg_hit(idx, `RDR_IDX_RX_CONFIG);
  assign wr_energy     = wr_en & reg_hit(idx, `RDR_IDX_ENERGY_LEVEL);
  assign wr_slice      = wr_en & reg_hit(idx, `RDR_IDX_SLICE_LEVEL);
  assign wr_filter     = wr_en & reg_hit(idx, `RDR_IDX_FILTER_SLICE);
  assign wr_cdro       = wr_en & reg_hit(idx, `RDR_IDX_CDR_OPTIONS);
  assign wr_fmt        = wr_en & reg_hit(idx, `RDR_IDX_DATA_FORMAT);
  assign wr_coef       = wr_en & reg_hit(idx, `RDR_IDX_LOOP_COEF);
  assign wr_rate       = wr_en & reg_hit(idx, `RDR_IDX_RATE_SELECT);
  assign rate_discrete = (wdata[7:3] == 5'h00);
  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  always @* begin
    rdata_d   = 8'h00;
    addr_ok_d = 1'b1;
    case (idx)
      {2'b00, `RDR_IDX_RX_CONFIG}:    rdata_d = rxc_q;
      {2'b00, `RDR_IDX_ENERGY_LEVEL}: rdata_d = energy_q;
      {2'b00, `RDR_IDX_SLICE_LEVEL}:  rdata_d = slice_q;
      {2'b00, `RDR_IDX_FILTER_SLICE}: rdata_d = filter_q & `RDR_FS_UNUSED_MASK;
      {2'b00, `RDR_IDX_CDR_OPTIONS}:  rdata_d = cdro_q;
      {2'b00, `RDR_IDX_DATA_FORMAT}:  rdata_d = fmt_q;
      {2'b00, `RDR_IDX_LOOP_COEF}:    rdata_d = coef_q;
      {2'b00, `RDR_IDX_RATE_SELECT}:  rdata_d = rate_q;
      {2'b00, `RDR_IDX_STATUS}:       rdata_d = {5'h00, demod_select_o, energy_met_q};
      default:                        addr_ok_d = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // apb slave, zero wait state
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~addr_ok_d;
      if (psel_i & ~penable_i & ~pwrite_i) begin
        prdata_o <= {24'h000000, rdata_d};
      end
    end
  end
  // ----------------------------------------------------------------
  // receive configuration
  // ----------------------------------------------------------------
  // writes land only at the access edge, when pready is already high
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxc_q <= `RDR_RST_RXC;
    end else if (wr_rxc) begin
      rxc_q <= wdata;
    end
  end
  // ----------------------------------------------------------------
  // energy detect level
  // ----------------------------------------------------------------
  // hardware noise-floor update wins over a software write
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      energy_q <= `RDR_RST_ENERGY;
    end else if (noise_floor_valid_i) begin
      energy_q <= noise_floor_level_i;
    end else if (wr_energy) begin
      energy_q <= wdata;
    end
  end
  // ----------------------------------------------------------------
  // slice level
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slice_q <= `RDR_RST_SLICE;
    end else if (wr_slice) begin
      slice_q <= wdata;
    end
  end
  // ----------------------------------------------------------------
  // filter and slice options
  // ----------------------------------------------------------------
  // bit 4 never stored, so it cannot leak into any field
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filter_q <= `RDR_RST_FILTER;
    end else if (wr_filter) begin
      filter_q <= wdata & `RDR_FS_UNUSED_MASK;
    end
  end
  // ----------------------------------------------------------------
  // recovery options and data format
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cdro_q <= `RDR_RST_CDRO;
    end else if (wr_cdro) begin
      cdro_q <= wdata;
    end
  end
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fmt_q <= `RDR_RST_FMT;
    end else if (wr_fmt) begin
      fmt_q <= wdata;
    end
  end
  // ----------------------------------------------------------------
  // rate select and loop coefficient
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_q <= `RDR_RST_RATE;
    end else if (wr_rate) begin
      rate_q <= wdata;
    end
  end
  // discrete rates preload; user rates keep the written value
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      coef_q <= `RDR_RST_COEF;
    end else if (wr_rate & rate_discrete) begin
      coef_q <= RATE_COEF_TABLE[wdata[2:0]*8 +: 8];
    end else if (wr_coef) begin
      coef_q <= wdata;
    end
  end
  // ----------------------------------------------------------------
  // energy detect routing
  // ----------------------------------------------------------------
  // compare is registered, so the recovery release lags one more clock
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      energy_met_q <= 1'b0;
    end else begin
      energy_met_q <= energy_level_i >= energy_q;
    end
  end
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      energy_threshold_o <= `RDR_RST_ENERGY;
    end else begin
      energy_threshold_o <= energy_q;
    end
  end
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_data_recovery_rst_o <= 1'b1;
    end else begin
      clock_data_recovery_rst_o <= rxc_q[`RDR_RXC_WAKE_BIT] & ~energy_met_q;
    end
  end
  // ----------------------------------------------------------------
  // am slicer routing
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slice_threshold_o <= `RDR_RST_SLICE;
    end else begin
      case (ref_sel)
        `RDR_REF_AVERAGE: slice_threshold_o <= average_level_i;
        `RDR_REF_PEAK:    slice_threshold_o <= half_level(peak_level_i);
        default:          slice_threshold_o <= slice_q;
      endcase
    end
  end
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      signal_strength_level_filter_bw_select_o <= 3'h0;
    end else begin
      signal_strength_level_filter_bw_select_o <= filter_q[`RDR_FS_BW_HI:`RDR_FS_BW_LO];
    end
  end
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slice_hysteresis_mv_o <= `RDR_HYST_MV_0;
    end else begin
      slice_hysteresis_mv_o <= hyst_mv(filter_q[`RDR_FS_HYST_HI:`RDR_FS_HYST_LO]);
    end
  end
  // ----------------------------------------------------------------
  // demodulator and clock recovery routing
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_modulation_select_o <= 1'b0;
    end else begin
      rx_modulation_select_o <= rxc_q[`RDR_RXC_MOD_BIT];
    end
  end
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      demod_select_o <= `RDR_DEMOD_AM;
    end else if (rxc_q[`RDR_RXC_MOD_BIT]) begin
      demod_select_o <= `RDR_DEMOD_AM;
    end else if (cdro_q[`RDR_CDRO_FMMODE_BIT]) begin
      demod_select_o <= `RDR_DEMOD_PLL;
    end else begin
      demod_select_o <= `RDR_DEMOD_FFT;
    end
  end
  // recovery optional in am, enabled by its option bit
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_data_recovery_en_o <= 1'b0;
    end else if (rxc_q[`RDR_RXC_MOD_BIT]) begin
      clock_data_recovery_en_o <= cdro_q[`RDR_CDRO_FMMODE_BIT];
    end else begin
      clock_data_recovery_en_o <= 1'b1;
    end
  end
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fsk_loop_filter_coef_o <= `RDR_RST_COEF;
    end else begin
      fsk_loop_filter_coef_o <= coef_q;
    end
  end
  // ----------------------------------------------------------------
  // frame alignment routing
  // ----------------------------------------------------------------
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sof_pattern_o <= 8'h00;
    end else begin
      sof_pattern_o <= manch ? `RDR_SOF_MAN : 8'h00;
    end
  end
endmodule

// ==== verification/rdr_config_asserts.sv ====
// assertion checker for the data-recovery register block
`timescale 1ns/100ps
module rdr_config_asserts (
  input wire        clock_i,
  input wire        rst_n_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        noise_floor_valid_i,
  input wire [7:0]  noise_floor_level_i,
  input wire [7:0]  energy_threshold_o,
  input wire [7:0]  slice_hysteresis_mv_o,
  input wire        rx_modulation_select_o,
  input wire [1:0]  demod_select_o,
  input wire        clock_data_recovery_en_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ready_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready_o |=> !pready_o) else $error("ready too long");
  error_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("lone error");
  error_reads_zero_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("error read not zero");
  read_byte_only_a: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  hyst_legal_a: assert property (slice_hysteresis_mv_o inside {8'h00, 8'h19, 8'h32, 8'h64})
    else $error("bad hysteresis");
  fm_recovery_on_a: assert property (!rx_modulation_select_o && !$past(rx_modulation_select_o)
    && $past(rst_n_i) |-> clock_data_recovery_en_o) else $error("fm without recovery");
  fm_demod_a: assert property (!rx_modulation_select_o && !$past(rx_modulation_select_o)
    && $past(rst_n_i) |-> demod_select_o != 2'h0) else $error("fm uses am detector");
  am_demod_a: assert property (rx_modulation_select_o && $past(rx_modulation_select_o)
    |-> demod_select_o == 2'h0) else $error("am wrong detector");
  noise_overwrite_a: assert property (noise_floor_valid_i |=> ##1
    energy_threshold_o == $past(noise_floor_level_i, 2)) else $error("noise floor lost");
  cover property (pslverr_o);
  cover property (pready_o && pwrite_i);
  cover property (noise_floor_valid_i);
endmodule
bind rdr_config rdr_config_asserts rdr_config_asserts_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .noise_floor_valid_i(noise_floor_valid_i),
  .noise_floor_level_i(noise_floor_level_i), .energy_threshold_o(energy_threshold_o),
  .slice_hysteresis_mv_o(slice_hysteresis_mv_o), .demod_select_o(demod_select_o),
  .rx_modulation_select_o(rx_modulation_select_o),
  .clock_data_recovery_en_o(clock_data_recovery_en_o));

// ==== verification/rdr_rf_model.sv ====
// far-side signal source feeding detector levels
`timescale 1ns/100ps
module rdr_rf_model (
  input  wire       clock_i,
  input  wire       rst_n_i,
  input  wire [7:0] energy_i,
  input  wire       nf_go_i,
  output reg  [7:0] energy_level_o,
  output reg  [7:0] peak_level_o,
  output reg  [7:0] average_level_o,
  output reg        noise_floor_valid_o,
  output reg  [7:0] noise_floor_level_o
);
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      energy_level_o <= 8'h00;
      noise_floor_valid_o <= 1'b0;
      noise_floor_level_o <= 8'h00;
      peak_level_o <= 8'h00;
      average_level_o <= 8'h00;
    end else begin
      // steady levels of an alternating preamble, no long identical runs
      peak_level_o <= 8'hA0;
      average_level_o <= 8'h30;
      energy_level_o <= energy_i;
      noise_floor_valid_o <= nf_go_i;
      // level is only meaningful with the strobe, so it churns otherwise
      noise_floor_level_o <= nf_go_i ? 8'h33 : ~noise_floor_level_o;
    end
  end
endmodule

// ==== verification/rdr_config_test.sv ====
// self-checking bench for the data-recovery register block
`timescale 1ns/100ps
`include "rdr_consts.vh"
module rdr_config_test;
  logic        clock_i, rst_n_i, psel, pen, pwr, pready, perr, nf_go, nf_v, mod, cdr_en, cdr_rst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  en_lvl, e_l, p_l, a_l, nf_l, e_thr, s_thr, hyst, coef, sof;
  logic [2:0]  bw;
  logic [1:0]  dsel;
  logic        er;
  int          miscompares = 0, n_checks = 0;
  rdr_rf_model rdr_rf_model_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .energy_i(en_lvl),
    .nf_go_i(nf_go), .energy_level_o(e_l), .peak_level_o(p_l), .average_level_o(a_l),
    .noise_floor_valid_o(nf_v), .noise_floor_level_o(nf_l));
  rdr_config rdr_config_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(perr), .noise_floor_valid_i(nf_v), .noise_floor_level_i(nf_l),
    .energy_level_i(e_l), .peak_level_i(p_l), .average_level_i(a_l), .energy_threshold_o(e_thr),
    .slice_threshold_o(s_thr), .signal_strength_level_filter_bw_select_o(bw), .slice_hysteresis_mv_o(hyst),
    .fsk_loop_filter_coef_o(coef), .rx_modulation_select_o(mod), .demod_select_o(dsel),
    .clock_data_recovery_en_o(cdr_en), .clock_data_recovery_rst_o(cdr_rst), .sof_pattern_o(sof));
  initial begin
    clock_i = 0;
    forever #20 clock_i = ~clock_i;
  end
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) miscompares++;
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
    repeat (3) @(posedge clock_i);
  endtask
  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  task t_regs;
    rdchk(`RDR_IDX_ENERGY_LEVEL, 0);
    wr(`RDR_IDX_ENERGY_LEVEL, 8'hA5);
    rdchk(`RDR_IDX_ENERGY_LEVEL, 32'hA5);
    chk(e_thr, 8'hA5);
    wr(`RDR_IDX_FILTER_SLICE, 8'hFF);
    rdchk(`RDR_IDX_FILTER_SLICE, 32'hEF);
    wr(`RDR_IDX_LOOP_COEF, 8'h5A);
    chk(coef, 8'h5A);
    wr(`RDR_IDX_RATE_SELECT, 8'h03);
    rdchk(`RDR_IDX_LOOP_COEF, 32'h40);
  endtask
  task t_slice;
    logic [7:0] hy [4];
    logic [7:0] sl [4];
    hy = '{8'h00, 8'h19, 8'h32, 8'h64};
    sl = '{8'h40, 8'h30, 8'h50, 8'h40};
    wr(`RDR_IDX_SLICE_LEVEL, 8'h40);
    rdchk(`RDR_IDX_SLICE_LEVEL, 32'h40);
    wr(`RDR_IDX_DATA_FORMAT, 8'h08);
    for (int i = 0; i < 8; i++) begin
      wr(`RDR_IDX_FILTER_SLICE, {i[2:0], 1'b1, i[1:0], i[1:0]});
      chk(bw, i[2:0]);
      chk(hyst, hy[i%4]);
      chk(s_thr, sl[i%4]);
    end
  endtask
  task t_mod;
    for (int i = 0; i < 4; i++) begin
      wr(`RDR_IDX_RX_CONFIG, {5'h0, i[1], 2'h0});
      wr(`RDR_IDX_CDR_OPTIONS, {7'h0, i[0]});
      chk(mod, i[1]);
      chk(dsel, i[1] ? 2'h0 : (i[0] ? 2'h2 : 2'h1));
      chk(cdr_en, i[1] ? i[0] : 1'b1);
    end
    wr(`RDR_IDX_DATA_FORMAT, 8'h08);
    chk(sof, 8'h66);
    wr(`RDR_IDX_DATA_FORMAT, 8'h00);
    chk(sof, 8'h00);
  endtask
  task t_energy;
    wr(`RDR_IDX_ENERGY_LEVEL, 8'h40);
    wr(`RDR_IDX_RX_CONFIG, 8'h01);
    chk(cdr_rst, 1'b1);
    en_lvl <= 8'h50;
    repeat (4) @(posedge clock_i);
    chk(cdr_rst, 1'b0);
    rdchk(`RDR_IDX_STATUS, 32'h05);
    nf_go <= 1'b1;
    @(posedge clock_i);
    nf_go <= 1'b0;
    repeat (3) @(posedge clock_i);
    rdchk(`RDR_IDX_ENERGY_LEVEL, 32'h33);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h20, 32'h5A);
    chk(er, 1'b1);
  endtask
  task t_reset;
    wr(`RDR_IDX_SLICE_LEVEL, 8'h7E);
    rst_n_i <= 1'b0;
    @(posedge clock_i);
    chk(cdr_rst, 1'b1);
    chk(e_thr, 8'h00);
    chk(pready, 1'b0);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    rdchk(`RDR_IDX_SLICE_LEVEL, 32'h0);
  endtask
  initial begin
    {rst_n_i, psel, pen, pwr, nf_go} = 0;
    paddr = 0;
    pwdata = 0;
    en_lvl = 8'h10;
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_slice;
    t_mod;
    t_energy;
    t_reset;
    final_report;
  end
  initial begin
    #400000;
    miscompares++;
    final_report;
  end
endmodule
